// [logic/bmf_pkg.sv]
// Constants, types and helpers for the bus-matching FIFO core.
// Assumes a single clock domain; straps are sampled while reset is low.
package bmf_pkg;

    localparam int DATA_W = 36;
    localparam int DEPTH_DEF = 1024;
    localparam int APB_AW = 12;

    localparam logic [11:0] ADDR_STATUS = 12'h000;
    localparam logic [11:0] ADDR_CONFIG = 12'h004;
    localparam logic [11:0] ADDR_EMPTY_OFF = 12'h008;
    localparam logic [11:0] ADDR_FULL_OFF = 12'h00C;

    // Default offsets indexed by {load, sel_high, sel_low}
    localparam logic [15:0] DEF_OFFS [8] = '{16'h0007, 16'h000F, 16'h001F, 16'h003F,
                                             16'h007F, 16'h00FF, 16'h01FF, 16'h03FF};

    localparam logic [35:0] MASK_9 = 36'h0_0000_01FF;
    localparam logic [35:0] MASK_18 = 36'h0_0003_FFFF;
    localparam logic [35:0] MASK_36 = 36'hF_FFFF_FFFF;
    localparam logic [5:0] SHIFT_9 = 6'h09;
    localparam logic [5:0] SHIFT_18 = 6'h12;
    localparam logic [2:0] UNITS_1 = 3'h1;
    localparam logic [2:0] UNITS_2 = 3'h2;
    localparam logic [2:0] UNITS_4 = 3'h4;

    typedef enum logic [2:0] {BMF_W36_36, BMF_W36_18, BMF_W36_9, BMF_W18_36, BMF_W9_36} bmf_width_t;

    typedef struct packed {
        bmf_width_t width;
        logic little_end;
        logic first_word_fallthrough;
        logic serial_prog;
        logic interspersed;
        logic zero_lat_rt;
        logic sync_flags;
    } bmf_cfg_t;

    typedef struct packed {
        logic [15:0] count;
        logic [10:0] rsvd;
        logic paf_n;
        logic pae_n;
        logic hf_n;
        logic ff_n;
        logic ef_n;
    } bmf_status_t;

    function automatic bmf_width_t bmf_decode_width(input logic bm, input logic iw, input logic ow);
        case ({bm, iw, ow})
            3'h4: return BMF_W36_18;
            3'h5: return BMF_W36_9;
            3'h6: return BMF_W18_36;
            3'h7: return BMF_W9_36;
            default: return BMF_W36_36;
        endcase
    endfunction : bmf_decode_width

    // Interspersed: parity at 8, 17, 26, 35 dropped; else low 32 bits
    function automatic logic [31:0] bmf_pack_offset(input logic [35:0] d, input logic inter);
        return inter ? {d[34:27], d[25:18], d[16:9], d[7:0]} : d[31:0];
    endfunction : bmf_pack_offset

endpackage : bmf_pkg

// [logic/bmf_fifo_core.sv]
// Bus-matching FIFO core: strap capture, storage, offsets, status flags.
// Assumes one clock; clock runs during reset; APB master per AMBA rules.
//
// Added by the designer: the APB interface to the registers and the register addresses.
`timescale 1ns/1ns
module bmf_fifo_core
    import bmf_pkg::*;
#(
    parameter int DEPTH = DEPTH_DEF
)
(
    input wire logic i_clk,
    input wire logic i_rst_n,
    input wire logic i_bus_match_select,
    input wire logic i_input_width_select,
    input wire logic i_output_width_select,
    input wire logic i_byte_order_select,
    input wire logic i_default_offset_sel_low,
    input wire logic i_default_offset_sel_high,
    input wire logic i_fallthrough_or_serial_in,
    input wire logic i_parity_placement_select,
    input wire logic i_retransmit_latency_select,
    input wire logic i_flag_timing_select,
    input wire logic i_offset_access_load,
    input wire logic i_serial_load_enable,
    input wire logic i_write_en,
    input wire logic [DATA_W-1:0] i_write_data_in,
    input wire logic i_read_en,
    input wire logic i_output_enable_n,
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic i_pwrite,
    input wire logic [APB_AW-1:0] i_paddr,
    input wire logic [31:0] i_pwdata,
    output logic [DATA_W-1:0] o_read_data_out,
    output logic o_read_data_oe,
    output logic o_empty_or_valid_out_n,
    output logic o_full_or_space_out_n,
    output logic o_half_full_indication_n,
    output logic o_almost_empty_indication_n,
    output logic o_almost_full_indication_n,
    output logic [31:0] o_prdata,
    output logic o_pready,
    output logic o_pslverr
);

    localparam int AW = $clog2(DEPTH);
    localparam int CW = AW + 1;
    localparam logic [CW-1:0] DEPTH_C = CW'(DEPTH);
    localparam logic [CW-1:0] HALF_C = CW'(DEPTH / 2);

    function automatic logic [2:0] units_wr(input bmf_width_t w);
        return (w == BMF_W18_36) ? UNITS_2 : (w == BMF_W9_36) ? UNITS_4 : UNITS_1;
    endfunction : units_wr

    function automatic logic [2:0] units_rd(input bmf_width_t w);
        return (w == BMF_W36_18) ? UNITS_2 : (w == BMF_W36_9) ? UNITS_4 : UNITS_1;
    endfunction : units_rd

    function automatic logic [35:0] piece_mask(input logic [2:0] units);
        return (units == UNITS_4) ? MASK_9 : (units == UNITS_2) ? MASK_18 : MASK_36;
    endfunction : piece_mask

    // Bit offset of piece idx; big-endian puts the first piece on top
    function automatic logic [5:0] piece_shift(input logic [1:0] idx, input logic [2:0] units, input logic big);
        logic [2:0] pos;
        pos = big ? 3'(units - UNITS_1 - {1'b0, idx}) : {1'b0, idx};
        return (units == UNITS_4) ? 6'(pos * SHIFT_9) : (units == UNITS_2) ? 6'(pos * SHIFT_18) : 6'h00;
    endfunction : piece_shift

    bmf_cfg_t cfg_reg;
    logic [DATA_W-1:0] mem [DEPTH];
    logic [CW-1:0] wp_reg, rp_reg, cnt, free_cnt;
    logic [1:0] wr_idx_reg, rd_idx_reg;
    logic [DATA_W-1:0] asm_reg, asm_word, piece_in, src_word, piece_out, q_reg;
    logic [DATA_W-1:0] hold_reg;
    logic hold_valid_reg, out_valid_reg, rd_sel_reg, wr_sel_reg;
    logic [CW-1:0] e_off_reg, f_off_reg, def_off;
    logic [2:0] wr_units, rd_units;
    logic full, avail, wr_fire, commit, take, pop, last;
    logic ld, par_load, ser_load, apb_acc, apb_wr;
    bmf_status_t status;

    ////////////////////////////////////////////////////////////////////////
    // Strap capture

    // Sampled every edge while reset is low, frozen from release on
    always_ff @(posedge i_clk)
    begin
        if (!i_rst_n)
        begin
            cfg_reg.width <= bmf_decode_width(i_bus_match_select, i_input_width_select,
                                              i_output_width_select);
            cfg_reg.little_end <= i_byte_order_select;
            cfg_reg.first_word_fallthrough <= i_fallthrough_or_serial_in;
            cfg_reg.serial_prog <= i_offset_access_load;
            cfg_reg.interspersed <= i_parity_placement_select;
            cfg_reg.zero_lat_rt <= !i_retransmit_latency_select;
            cfg_reg.sync_flags <= i_flag_timing_select;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Write side

    // Single clock domain: pointers compare directly, no crossing needed
    assign cnt = wp_reg - rp_reg;
    assign free_cnt = DEPTH_C - cnt;
    assign full = (cnt == DEPTH_C);
    assign ld = i_offset_access_load;
    assign wr_units = units_wr(cfg_reg.width);
    assign wr_fire = i_write_en && !ld && !full;
    assign piece_in = i_write_data_in & piece_mask(wr_units);
    assign asm_word = asm_reg | (piece_in << piece_shift(wr_idx_reg, wr_units, !cfg_reg.little_end));
    assign commit = wr_fire && ({1'b0, wr_idx_reg} == 3'(wr_units - UNITS_1));

    always_ff @(posedge i_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            wp_reg <= '0;
            wr_idx_reg <= '0;
            asm_reg <= '0;
        end
        else if (wr_fire)
        begin
            if (commit)
            begin
                wp_reg <= wp_reg + 1'b1;
                wr_idx_reg <= '0;
                asm_reg <= '0;
            end
            else
            begin
                wr_idx_reg <= wr_idx_reg + 1'b1;
                asm_reg <= asm_word;
            end
        end
    end

    // Data stored as written; parity placement never touches it
    always_ff @(posedge i_clk)
    begin
        if (commit)
        begin
            mem[wp_reg[AW-1:0]] <= asm_word;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Read side

    assign rd_units = units_rd(cfg_reg.width);
    assign avail = hold_valid_reg || (cnt != '0);
    assign take = !ld && avail && (cfg_reg.first_word_fallthrough ? (!out_valid_reg || i_read_en) : i_read_en);
    assign src_word = hold_valid_reg ? hold_reg : mem[rp_reg[AW-1:0]];
    assign pop = take && !hold_valid_reg;
    assign last = ({1'b0, rd_idx_reg} == 3'(rd_units - UNITS_1));
    assign piece_out = (src_word >> piece_shift(rd_idx_reg, rd_units, !cfg_reg.little_end)) & piece_mask(rd_units);

    always_ff @(posedge i_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            rp_reg <= '0;
            rd_idx_reg <= '0;
            hold_reg <= '0;
            hold_valid_reg <= 1'b0;
            q_reg <= '0;
            out_valid_reg <= 1'b0;
            rd_sel_reg <= 1'b0;
        end
        else if (take)
        begin
            q_reg <= piece_out;
            out_valid_reg <= 1'b1;
            hold_reg <= src_word;
            if (pop)
            begin
                rp_reg <= rp_reg + 1'b1;
            end
            hold_valid_reg <= !last;
            rd_idx_reg <= last ? 2'h0 : 2'(rd_idx_reg + 1'b1);
        end
        else if (ld && i_read_en)
        begin
            q_reg <= DATA_W'(rd_sel_reg ? f_off_reg : e_off_reg);
            rd_sel_reg <= !rd_sel_reg;
        end
        else if (i_read_en)
        begin
            out_valid_reg <= 1'b0;
        end
    end

    always_ff @(posedge i_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            o_read_data_oe <= 1'b0;
        end
        else
        begin
            o_read_data_oe <= !i_output_enable_n;
        end
    end

    assign o_read_data_out = q_reg;

    ////////////////////////////////////////////////////////////////////////
    // Offset registers

    assign def_off = CW'(DEF_OFFS[{i_offset_access_load, i_default_offset_sel_high, i_default_offset_sel_low}]);
    assign par_load = ld && i_write_en && !cfg_reg.serial_prog;
    assign ser_load = ld && i_serial_load_enable && cfg_reg.serial_prog;

    always_ff @(posedge i_clk)
    begin
        if (!i_rst_n)
        begin
            e_off_reg <= def_off;
            f_off_reg <= def_off;
            wr_sel_reg <= 1'b0;
        end
        else if (apb_wr && (i_paddr == ADDR_EMPTY_OFF))
        begin
            e_off_reg <= CW'(i_pwdata);
        end
        else if (apb_wr && (i_paddr == ADDR_FULL_OFF))
        begin
            f_off_reg <= CW'(i_pwdata);
        end
        else if (par_load)
        begin
            if (wr_sel_reg)
            begin
                f_off_reg <= CW'(bmf_pack_offset(i_write_data_in, cfg_reg.interspersed));
            end
            else
            begin
                e_off_reg <= CW'(bmf_pack_offset(i_write_data_in, cfg_reg.interspersed));
            end
            wr_sel_reg <= !wr_sel_reg;
        end
        else if (ser_load)
        begin
            // Bits enter the empty offset LSB and shift through into the full offset
            {f_off_reg, e_off_reg} <= {f_off_reg[CW-2:0], e_off_reg, i_fallthrough_or_serial_in};
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Status flags, active low

    always_ff @(posedge i_clk)
    begin
        if (!i_rst_n)
        begin
            o_empty_or_valid_out_n <= i_fallthrough_or_serial_in;
            o_full_or_space_out_n <= !i_fallthrough_or_serial_in;
            o_half_full_indication_n <= 1'b1;
            o_almost_empty_indication_n <= 1'b0;
            o_almost_full_indication_n <= 1'b1;
        end
        else
        begin
            o_empty_or_valid_out_n <= cfg_reg.first_word_fallthrough ? !out_valid_reg : avail;
            o_full_or_space_out_n <= cfg_reg.first_word_fallthrough ? full : !full;
            o_half_full_indication_n <= (cnt <= HALF_C);
            o_almost_empty_indication_n <= (cnt >= e_off_reg);
            o_almost_full_indication_n <= (free_cnt > f_off_reg);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // APB slave, one wait state

    assign apb_acc = i_psel && i_penable && !o_pready;
    assign apb_wr = i_psel && i_penable && o_pready && i_pwrite;

    always_comb
    begin
        status = '0;
        status.count = 16'(cnt);
        status.paf_n = o_almost_full_indication_n;
        status.pae_n = o_almost_empty_indication_n;
        status.hf_n = o_half_full_indication_n;
        status.ff_n = o_full_or_space_out_n;
        status.ef_n = o_empty_or_valid_out_n;
    end

    always_ff @(posedge i_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            o_pready <= 1'b0;
            o_prdata <= '0;
            o_pslverr <= 1'b0;
        end
        else
        begin
            o_pready <= apb_acc;
            o_pslverr <= 1'b0;
            if (apb_acc)
            begin
                case (i_paddr)
                    ADDR_STATUS: o_prdata <= status;
                    ADDR_CONFIG: o_prdata <= 32'(cfg_reg);
                    ADDR_EMPTY_OFF: o_prdata <= 32'(e_off_reg);
                    ADDR_FULL_OFF: o_prdata <= 32'(f_off_reg);
                    default:
                    begin
                        o_prdata <= '0;
                        o_pslverr <= 1'b1;
                    end
                endcase
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Checks

    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_rst_n);

    a_empty_flag_std: assert property (!cfg_reg.first_word_fallthrough |=> o_empty_or_valid_out_n == $past(avail))
        else $error("empty indication wrong");
    a_valid_flag_ft: assert property (cfg_reg.first_word_fallthrough |=> o_empty_or_valid_out_n == !$past(out_valid_reg))
        else $error("output valid indication wrong");
    a_full_flag_std: assert property (!cfg_reg.first_word_fallthrough |=> o_full_or_space_out_n == ($past(cnt) != DEPTH_C))
        else $error("full indication wrong");
    a_space_flag_ft: assert property (cfg_reg.first_word_fallthrough |=> o_full_or_space_out_n == ($past(cnt) == DEPTH_C))
        else $error("input space indication wrong");
    a_half_full_flag: assert property (##1 o_half_full_indication_n == ($past(cnt) <= HALF_C))
        else $error("half-full indication wrong");
    a_almost_empty_cmp: assert property (##1 o_almost_empty_indication_n == ($past(cnt) >= $past(e_off_reg)))
        else $error("almost-empty indication wrong");
    a_almost_full_cmp: assert property (##1 o_almost_full_indication_n == ($past(free_cnt) > $past(f_off_reg)))
        else $error("almost-full indication wrong");
    a_oe_follows_pin: assert property (##1 o_read_data_oe == !$past(i_output_enable_n))
        else $error("output enable not followed");
    a_cfg_held: assert property (##1 $stable(cfg_reg))
        else $error("configuration changed after reset");
    a_parity_load: assert property (par_load && !apb_wr |=>
        ($past(wr_sel_reg) ? f_off_reg : e_off_reg) ==
        CW'(bmf_pack_offset($past(i_write_data_in), cfg_reg.interspersed)))
        else $error("parallel offset load wrong");
    a_load_blocks_data: assert property (ld |=> $stable(wp_reg) && $stable(rp_reg))
        else $error("data moved while offset access");

    c_ft_first_word: cover property (cfg_reg.first_word_fallthrough && !out_valid_reg ##1 out_valid_reg);
    c_reaches_full: cover property (full);
    c_serial_load: cover property (ser_load);
    c_narrow_split: cover property (take && !last);

endmodule : bmf_fifo_core

// [test/bmf_host_model.sv]
// Host-side model: writing and reading hosts of the FIFO core.
// Assumes bench tasks call it; all pins change just after a rising edge.
`timescale 1ns/1ns
module bmf_host_model
    import bmf_pkg::*;
(
    input wire logic i_clk,
    input wire logic [DATA_W-1:0] i_read_data,
    output logic o_write_en,
    output logic [DATA_W-1:0] o_write_data,
    output logic o_read_en,
    output logic o_offset_access_load
);
    initial
    begin
        o_write_en = 1'b0;
        o_write_data = 36'h0_0000_0000;
        o_read_en = 1'b0;
        o_offset_access_load = 1'b0;
    end

    ////////////////////////////////////////////////////////////////////////
    // One write-port piece; ld high steers it to the offset registers
    task automatic put(input logic [DATA_W-1:0] d, input logic ld);
        @(posedge i_clk);
        o_offset_access_load <= ld;
        o_write_en <= 1'b1;
        o_write_data <= d;
        @(posedge i_clk);
        o_write_en <= 1'b0;
        o_offset_access_load <= 1'b0;
        o_write_data <= ~d;
    endtask : put

    // Level on the load pin, held until changed again
    task automatic hold_load(input logic ld);
        @(posedge i_clk);
        o_offset_access_load <= ld;
    endtask : hold_load

    // One read-port piece, sampled once the output register has moved
    task automatic get(output logic [DATA_W-1:0] v);
        @(posedge i_clk);
        o_read_en <= 1'b1;
        @(posedge i_clk);
        o_read_en <= 1'b0;
        #1 v = i_read_data;
    endtask : get
endmodule : bmf_host_model

// [test/bus_matching_fifo_config_flags_tb.sv]
// Self-checking bench: straps, flags, bus widths, offsets, fall-through.
// Assumes the core at DEPTH 256 and the host model on one 100 MHz clock.
`timescale 1ns/1ns
module bus_matching_fifo_config_flags_tb;
    import bmf_pkg::*;
    localparam int DEPTH = 256;
    logic i_clk = 1'b0;
    logic i_rst_n = 1'b0;
    logic [9:0] strap = 10'h000;
    logic oe_n = 1'b1;
    logic serial_load_enable = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0000_0000;
    logic wen, ren, ld, oe, evn, fsn, hfn, paen, pafn, pready, pslverr, er;
    logic [35:0] wdata, rdata, w, got;
    logic [31:0] prdata, rd;
    logic [35:0] q[$];
    int errors = 0;
    int checked = 0;
    int seed = 15;
    int offe, offf, nin, nout;
    int codes[5] = '{0, 4, 5, 6, 7};

    always #5 i_clk = ~i_clk;

    bmf_fifo_core #(.DEPTH(DEPTH)) bmf_fifo_core_i (
        .i_clk(i_clk), .i_rst_n(i_rst_n), .i_bus_match_select(strap[2]), .i_input_width_select(strap[1]),
        .i_output_width_select(strap[0]), .i_byte_order_select(strap[3]), .i_fallthrough_or_serial_in(strap[4]),
        .i_default_offset_sel_low(strap[5]), .i_default_offset_sel_high(strap[6]),
        .i_parity_placement_select(strap[7]), .i_retransmit_latency_select(strap[8]),
        .i_flag_timing_select(strap[9]), .i_offset_access_load(ld), .i_serial_load_enable(serial_load_enable),
        .i_write_en(wen), .i_write_data_in(wdata), .i_read_en(ren), .i_output_enable_n(oe_n),
        .i_psel(psel), .i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata),
        .o_read_data_out(rdata), .o_read_data_oe(oe), .o_empty_or_valid_out_n(evn),
        .o_full_or_space_out_n(fsn), .o_half_full_indication_n(hfn), .o_almost_empty_indication_n(paen),
        .o_almost_full_indication_n(pafn), .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr));

    bmf_host_model bmf_host_model_i (.i_clk(i_clk), .i_read_data(rdata), .o_write_en(wen),
        .o_write_data(wdata), .o_read_en(ren), .o_offset_access_load(ld));

    ////////////////////////////////////////////////////////////////////////
    task automatic wrap_up();
        $display("checks %0d errors %0d", checked, errors);
        if (errors == 0 && checked > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : wrap_up

    task automatic check(input string nm, input logic [35:0] seen, input logic [35:0] exp);
        checked++;
        if (seen !== exp)
        begin
            errors++;
            $display("mismatch %s expected %h seen %h", nm, exp, seen);
        end
    endtask : check

    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
        int n;
        n = 0;
        @(posedge i_clk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge i_clk);
        penable <= 1'b1;
        do
        begin
            @(posedge i_clk);
            n++;
        end
        while (pready !== 1'b1 && n < 50);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (n >= 50)
        begin
            errors++;
            wrap_up();
        end
    endtask : apb

    function automatic logic [35:0] piece(logic [35:0] v, int k, int n, logic be);
        int pw;
        int idx;
        pw = 36 / n;
        idx = be ? k : n - 1 - k;
        return (v >> (idx * pw)) & ((36'h1 << pw) - 1);
    endfunction : piece

    task automatic do_reset(input logic [9:0] s);
        @(posedge i_clk);
        i_rst_n <= 1'b0;
        strap <= s;
        repeat (12) @(posedge i_clk);
        check("rst_data", rdata, 36'h0);
        check("rst_ev", evn, s[4]);
        check("rst_fs", fsn, !s[4]);
        check("rst_flags", {hfn, paen, pafn}, 3'b101);
        i_rst_n <= 1'b1;
        q.delete();
        offe = DEF_OFFS[{1'b0, s[6], s[5]}];
        offf = offe;
        nin = (s[2] & s[1]) ? (s[0] ? 4 : 2) : 1;
        nout = (s[2] & !s[1]) ? (s[0] ? 4 : 2) : 1;
    endtask : do_reset

    task automatic flags();
        int c;
        c = q.size();
        repeat (2) @(posedge i_clk);
        #1;
        check("empty", evn, c != 0);
        check("full", fsn, c != DEPTH);
        check("half", hfn, !(c > DEPTH / 2));
        check("aempty", paen, c >= offe);
        check("afull", pafn, (DEPTH - c) > offf);
    endtask : flags

    // Junk in unused upper write bits must not reach storage
    task automatic push(input logic [35:0] v);
        logic [35:0] m;
        logic [35:0] d;
        m = (36'h1 << (36 / nin)) - 1;
        for (int k = 0; k < nin; k++)
        begin
            d = {$random(seed), 4'h0};
            d = (nin > 1) ? ((d & ~m) | piece(v, k, nin, strap[3])) : v;
            bmf_host_model_i.put(d, 1'b0);
        end
        if (q.size() < DEPTH)
            q.push_back(v);
    endtask : push

    task automatic pop();
        logic [35:0] v;
        v = q.size() ? q[0] : 36'h0;
        for (int k = 0; k < nout; k++)
        begin
            bmf_host_model_i.get(got);
            if (q.size())
                check("read", got, piece(v, k, nout, strap[3]));
        end
        if (q.size())
            v = q.pop_front();
    endtask : pop

    ////////////////////////////////////////////////////////////////////////
    initial
    begin
        do_reset(10'h300);
        apb(1'b0, ADDR_CONFIG, 32'h0);
        check("config", rd[8:2], 7'h00);
        apb(1'b0, 12'h010, 32'h0);
        check("unmapped", {er, rd}, 33'h1_0000_0000);
        apb(1'b1, ADDR_STATUS, 32'hFFFF_FFFF);
        apb(1'b0, ADDR_STATUS, 32'h0);
        check("status", rd, 32'h0000_0016);
        $display("test config done");
        for (int i = 0; i <= DEPTH; i++)
        begin
            push(36'({$random(seed), $random(seed)}));
            flags();
        end
        for (int i = 0; i <= DEPTH; i++)
        begin
            pop();
            flags();
        end
        $display("test fill drain done");
        for (int b = 0; b < 2; b++)
        begin
            @(posedge i_clk);
            oe_n <= b[0];
            repeat (2) @(posedge i_clk);
            #1 check("oe", oe, !b[0]);
        end
        $display("test output enable done");
        for (int i = 0; i < 10; i++)
        begin
            do_reset({6'h00, i[0], 3'(codes[i / 2])});
            apb(1'b0, ADDR_CONFIG, 32'h0);
            check("width", rd[8:5], {3'(i / 2), i[0]});
            push(36'({$random(seed), $random(seed)}));
            push(36'({$random(seed), $random(seed)}));
            pop();
            pop();
        end
        $display("test widths done");
        for (int p = 0; p < 2; p++)
        begin
            do_reset({2'b00, p[0], 7'h00});
            bmf_host_model_i.put(36'h8_0000_0105, 1'b1);
            bmf_host_model_i.put(36'h0_0000_0003, 1'b1);
            apb(1'b0, ADDR_EMPTY_OFF, 32'h0);
            check("off_empty", rd, p ? 32'h5 : 32'h105);
            apb(1'b0, ADDR_FULL_OFF, 32'h0);
            check("off_full", rd, 32'h3);
            offe = p ? 5 : 261;
            offf = 3;
            flags();
            push(36'h8_0000_0105);
            pop();
        end
        $display("test offsets done");
        bmf_host_model_i.hold_load(1'b1);
        do_reset(10'h000);
        apb(1'b0, ADDR_CONFIG, 32'h0);
        check("serial_cfg", rd[3], 1'b1);
        apb(1'b0, ADDR_EMPTY_OFF, 32'h0);
        check("def_off", rd, 32'(DEF_OFFS[4]));
        // Full offset bits first, empty offset LSB last
        w = 36'($random(seed)) & 36'h3_FFFF;
        for (int k = 17; k >= 0; k--)
        begin
            @(posedge i_clk);
            serial_load_enable <= 1'b1;
            strap[4] <= w[k];
        end
        @(posedge i_clk);
        serial_load_enable <= 1'b0;
        bmf_host_model_i.get(got);
        check("ser_empty", got, w[8:0]);
        bmf_host_model_i.get(got);
        check("ser_full", got, w[17:9]);
        bmf_host_model_i.hold_load(1'b0);
        offe = w[8:0];
        offf = w[17:9];
        flags();
        $display("test serial offsets done");
        do_reset(10'h010);
        w = 36'({$random(seed), $random(seed)});
        bmf_host_model_i.put(w, 1'b0);
        for (int n = 0; n < 20 && evn !== 1'b0; n++)
            @(posedge i_clk);
        #1 check("valid", evn, 1'b0);
        check("fw_data", rdata, w);
        check("space", fsn, 1'b0);
        $display("test fall-through done");
        wrap_up();
    end
endmodule : bus_matching_fifo_config_flags_tb
